// *** pwmos_top.v ***
// Output steering, mode, mask, dead zone and interrupt gating of the modulators
//
// Contract
// - Route bits 7..4 put second channel on P1.2, P0.6, P0.4, P0.2.
// - Low-side alternate route bit drives low-side output onto P3.6.
// - High-side routes: bit 2 onto P3.5, bit 0 onto P0.3, independent.
// - Bit 7 selects normal or half-bridge style of first modulator.
// - Mask enable with clear control high replaces both outputs by mask data.
// - Bits 5..4 choose one of four output modes, mode 0 after reset.
// - Bits 3..0 give dead zone of 0 to 15 modulator clock periods.
// - Modulator interrupt enable bit 7 passes modulator requests, reset 0.
// - Global gate bit 7 blocks all interrupts when 0.
// - Mask data bit 1 for low side, bit 0 for high side.
// - Run bit 4 starts first modulator, bit 5 starts channels 1 to 6.
// - Two-bit clock selects: 00/01 system, 10 RC, 11 double RC.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/100ps
`include "pwmos_consts.vh"

module pwmos_top #(
    parameter DZ_W = 4,
    parameter AW   = 10
) (
    // Clock, reset and modulator clock tick
    input  wire          clk_sys,
    input  wire          reset,
    input  wire          clk_en,
    // Avalon-MM slave
    input  wire [AW-1:0] avs_address,
    input  wire          avs_read,
    input  wire          avs_write,
    input  wire [31:0]   avs_writedata,
    input  wire [3:0]    avs_byteenable,
    output reg  [31:0]   avs_readdata_q,
    output reg           avs_waitrequest_q,
    // Raw waveforms and events from the modulator counters
    input  wire          first_duty,
    input  wire          first_low_duty,
    input  wire          group_duty,
    input  wire          first_modulator_clear,
    input  wire          ev_first_period,
    input  wire          ev_group_period,
    // Pins: drive high means the modulator owns the pin
    output reg  [7:0]    pin_drive_q,
    output reg  [7:0]    pin_level_q,
    // Modulator run and clock source controls
    output reg           first_modulator_run_q,
    output reg           group_modulator_run_q,
    output reg           first_clk_use_rc_q,
    output reg           first_clk_double_q,
    output reg           group_clk_use_rc_q,
    output reg           group_clk_double_q,
    // Interrupt request
    output reg           irq_q
);

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    reg  [7:0]           route_q;
    reg  [7:0]           mode_q;
    reg  [7:0]           runclk_q;
    reg                  global_irq_gate_q;
    reg                  modulator_irq_enable_q;
    reg  [`PWMOS_EV_W-1:0] sts_q;
    reg  [`PWMOS_EV_W-1:0] sts_d;
    reg  [`PWMOS_EV_W-1:0] ien_q;
    reg  [31:0]          rdata_d;

    wire [7:0]           idx;
    wire                 req;
    wire                 wr_go;
    wire [`PWMOS_EV_W-1:0] events;
    wire [`PWMOS_EV_W-1:0] clr_mask;

    assign idx   = avs_address[AW-1:2];
    assign req   = avs_read | avs_write;
    assign wr_go = avs_write & ~avs_waitrequest_q & avs_byteenable[`PWMOS_BE_LOW];

    // ------------------------------------------------------------------------
    // Field views
    // ------------------------------------------------------------------------
    wire                 bridge_style_select;
    wire                 force_mask_enable;
    wire [1:0]           pair_output_mode;
    wire [DZ_W-1:0]      dead_time_count;
    wire                 first_modulator_run;
    wire                 group_modulator_run;
    wire                 high_side_mask_level;
    wire                 low_side_mask_level;
    wire [1:0]           first_clk_sel;
    wire [1:0]           group_clk_sel;

    assign bridge_style_select  = mode_q[`PWMOS_MD_BRIDGE];
    assign force_mask_enable    = mode_q[`PWMOS_MD_MSKE];
    assign pair_output_mode     = mode_q[`PWMOS_MD_OM_HI:`PWMOS_MD_OM_LO];
    assign dead_time_count      = mode_q[`PWMOS_MD_DZ_HI:`PWMOS_MD_DZ_LO];
    assign first_modulator_run  = runclk_q[`PWMOS_RC_FRUN];
    assign group_modulator_run  = runclk_q[`PWMOS_RC_GRUN];
    assign high_side_mask_level = runclk_q[`PWMOS_RC_HI_MSK];
    assign low_side_mask_level  = runclk_q[`PWMOS_RC_LO_MSK];
    assign first_clk_sel        = runclk_q[`PWMOS_RC_FCKS_HI:`PWMOS_RC_FCKS_LO];
    assign group_clk_sel        = runclk_q[`PWMOS_RC_GCKS_HI:`PWMOS_RC_GCKS_LO];

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    always @* begin
        rdata_d = 32'h0000_0000;
        case (idx)
            `PWMOS_IDX_RUNCLK: begin
                rdata_d[7:0] = runclk_q;
            end
            `PWMOS_IDX_ROUTE: begin
                rdata_d[7:0] = route_q;
            end
            `PWMOS_IDX_MODE: begin
                rdata_d[7:0] = mode_q;
            end
            `PWMOS_IDX_GATE: begin
                rdata_d[`PWMOS_IRQ_EN_BIT] = global_irq_gate_q;
            end
            `PWMOS_IDX_MODIE: begin
                rdata_d[`PWMOS_IRQ_EN_BIT] = modulator_irq_enable_q;
            end
            `PWMOS_IDX_STS: begin
                rdata_d[`PWMOS_EV_W-1:0] = sts_q;
            end
            `PWMOS_IDX_IEN: begin
                rdata_d[`PWMOS_EV_W-1:0] = ien_q;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------------
    // One wait cycle per access; read data is
    // latched as waitrequest drops.
    always @(posedge clk_sys) begin
        if (reset) begin
            avs_waitrequest_q <= `PWMOS_RST_WAIT;
            avs_readdata_q    <= 32'h0000_0000;
        end else if (clk_en) begin
            if (avs_waitrequest_q && req) begin
                avs_waitrequest_q <= 1'b0;
                avs_readdata_q    <= rdata_d;
            end else begin
                avs_waitrequest_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (reset) begin
            route_q                <= `PWMOS_RST_BYTE;
            mode_q                 <= `PWMOS_RST_BYTE;
            runclk_q               <= `PWMOS_RST_BYTE;
            global_irq_gate_q      <= 1'b0;
            modulator_irq_enable_q <= 1'b0;
            ien_q                  <= {`PWMOS_EV_W{1'b0}};
        end else if (clk_en && wr_go) begin
            case (idx)
                `PWMOS_IDX_RUNCLK: begin
                    runclk_q <= avs_writedata[7:0];
                end
                `PWMOS_IDX_ROUTE: begin
                    route_q <= avs_writedata[7:0];
                end
                `PWMOS_IDX_MODE: begin
                    mode_q <= avs_writedata[7:0];
                end
                `PWMOS_IDX_GATE: begin
                    global_irq_gate_q <= avs_writedata[`PWMOS_IRQ_EN_BIT];
                end
                `PWMOS_IDX_MODIE: begin
                    modulator_irq_enable_q <= avs_writedata[`PWMOS_IRQ_EN_BIT];
                end
                `PWMOS_IDX_IEN: begin
                    ien_q <= avs_writedata[`PWMOS_EV_W-1:0];
                end
                default: begin
                    route_q <= route_q;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Sticky event status
    // ------------------------------------------------------------------------
    assign events   = {ev_group_period, ev_first_period};
    assign clr_mask = (wr_go && idx == `PWMOS_IDX_CLR) ?
                      avs_writedata[`PWMOS_EV_W-1:0] : {`PWMOS_EV_W{1'b0}};

    // A new event in the clearing cycle survives the clear
    always @* begin
        sts_d = (sts_q & ~clr_mask) | events;
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            sts_q <= {`PWMOS_EV_W{1'b0}};
        end else if (clk_en) begin
            sts_q <= sts_d;
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else if (clk_en) begin
            irq_q <= global_irq_gate_q & modulator_irq_enable_q & (|(sts_q & ien_q));
        end
    end

    // ------------------------------------------------------------------------
    // First modulator pair
    // ------------------------------------------------------------------------
    wire            first_raw;
    wire            first_low_raw;
    wire [DZ_W-1:0] dz_applied;
    wire            dt_high;
    wire            dt_low;
    reg             pair_high;
    reg             pair_low;
    reg             high_side_output;
    reg             low_side_output;

    assign first_raw     = first_modulator_run & first_duty;
    assign first_low_raw = first_modulator_run & first_low_duty;
    // Bypass the dead zone in half-bridge style
    // instead of trusting software.
    assign dz_applied    = bridge_style_select ? `PWMOS_DZ_NONE : dead_time_count;

    pwmos_dead_time #(
        .CW         (DZ_W)
    ) u_dead_time (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .clk_en     (clk_en),
        .raw_in     (first_raw),
        .dead_count (dz_applied),
        .high_out   (dt_high),
        .low_out    (dt_low)
    );

    always @* begin
        if (bridge_style_select) begin
            pair_high = first_raw;
            pair_low  = first_low_raw;
        end else begin
            pair_high = dt_high & first_modulator_run;
            pair_low  = dt_low & first_modulator_run;
        end
        // Mode bit 0 inverts the high side, bit 1 the low side
        high_side_output = pair_high ^ pair_output_mode[0];
        low_side_output  = pair_low ^ pair_output_mode[1];
        if (force_mask_enable && first_modulator_clear) begin
            high_side_output = high_side_mask_level;
            low_side_output  = low_side_mask_level;
        end
    end

    // ------------------------------------------------------------------------
    // Pin steering
    // ------------------------------------------------------------------------
    wire       group_wave;
    wire [7:0] wave_by_pin;

    assign group_wave  = group_modulator_run & group_duty;
    assign wave_by_pin = {{4{group_wave}}, low_side_output, high_side_output,
                          low_side_output, high_side_output};

    // Unowned pins are held low so the port
    // mux never sees a stale waveform.
    always @(posedge clk_sys) begin
        if (reset) begin
            pin_drive_q <= `PWMOS_RST_BYTE;
            pin_level_q <= `PWMOS_RST_BYTE;
        end else if (clk_en) begin
            pin_drive_q <= route_q;
            pin_level_q <= wave_by_pin & route_q;
        end
    end

    // ------------------------------------------------------------------------
    // Run and clock source outputs
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (reset) begin
            first_modulator_run_q <= 1'b0;
            group_modulator_run_q <= 1'b0;
            first_clk_use_rc_q    <= 1'b0;
            first_clk_double_q    <= 1'b0;
            group_clk_use_rc_q    <= 1'b0;
            group_clk_double_q    <= 1'b0;
        end else if (clk_en) begin
            first_modulator_run_q <= first_modulator_run;
            group_modulator_run_q <= group_modulator_run;
            first_clk_use_rc_q    <= first_clk_sel[`PWMOS_CKS_RC_BIT];
            first_clk_double_q    <= (first_clk_sel == `PWMOS_CKS_RC_X2);
            group_clk_use_rc_q    <= group_clk_sel[`PWMOS_CKS_RC_BIT];
            group_clk_double_q    <= (group_clk_sel == `PWMOS_CKS_RC_X2);
        end
    end

endmodule

// *** pwmos_consts.vh ***
// Register indices, field positions and codes of the modulator output stage
`ifndef PWMOS_CONSTS_VH
`define PWMOS_CONSTS_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PWMOS_IDX_RUNCLK    8'hA1
`define PWMOS_IDX_ROUTE     8'hA6
`define PWMOS_IDX_MODE      8'hA7
`define PWMOS_IDX_GATE      8'hA8
`define PWMOS_IDX_MODIE     8'hA9
`define PWMOS_IDX_STS       8'hB0
`define PWMOS_IDX_CLR       8'hB1
`define PWMOS_IDX_IEN       8'hB2
`define PWMOS_RST_BYTE      8'h00
`define PWMOS_RST_WAIT      1'h1

// ----------------------------------------------------------------------------
// Mode and dead-zone register fields
// ----------------------------------------------------------------------------
`define PWMOS_MD_BRIDGE     7
`define PWMOS_MD_MSKE       6
`define PWMOS_MD_OM_HI      5
`define PWMOS_MD_OM_LO      4
`define PWMOS_MD_DZ_HI      3
`define PWMOS_MD_DZ_LO      0
`define PWMOS_DZ_NONE       4'h0

// ----------------------------------------------------------------------------
// Run, clock select and mask level register fields
// ----------------------------------------------------------------------------
`define PWMOS_RC_GCKS_HI    7
`define PWMOS_RC_GCKS_LO    6
`define PWMOS_RC_GRUN       5
`define PWMOS_RC_FRUN       4
`define PWMOS_RC_FCKS_HI    3
`define PWMOS_RC_FCKS_LO    2
`define PWMOS_RC_LO_MSK     1
`define PWMOS_RC_HI_MSK     0
`define PWMOS_CKS_RC        2'h2
`define PWMOS_CKS_RC_X2     2'h3
`define PWMOS_CKS_RC_BIT    1

// ----------------------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------------------
`define PWMOS_IRQ_EN_BIT    7
`define PWMOS_EV_W          2
`define PWMOS_BE_LOW        0

`endif

// *** pwmos_dead_time.v ***
// Dead-zone inserter producing a complementary pair from one waveform
`timescale 1ns/100ps

module pwmos_dead_time #(
    parameter CW = 4
) (
    // Clock and reset
    input  wire          clk_sys,
    input  wire          reset,
    input  wire          clk_en,
    // Waveform and dead length in modulator clock periods
    input  wire          raw_in,
    input  wire [CW-1:0] dead_count,
    // Complementary pair
    output wire          high_out,
    output wire          low_out
);

    reg          level_q;
    reg [CW-1:0] cnt_q;
    wire         settled;

    // ------------------------------------------------------------------------
    // Both sides stay low for dead_count periods after each edge
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (reset) begin
            level_q <= 1'b0;
            cnt_q   <= {CW{1'b0}};
        end else if (clk_en) begin
            if (raw_in != level_q) begin
                level_q <= raw_in;
                cnt_q   <= dead_count;
            end else if (cnt_q != {CW{1'b0}}) begin
                cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    assign settled  = (cnt_q == {CW{1'b0}});
    assign high_out = level_q & settled;
    assign low_out  = ~level_q & settled;

endmodule

// *** pwmos_top_asserts.sv ***
// Checker of bus timing, pin routing, masking and interrupt gating
`timescale 1ns/100ps
`include "pwmos_consts.vh"
module pwmos_top_chk #(
    parameter DZ_W = 4,
    parameter AW   = 10
) (
    // Clock and reset
    input wire          clk_sys,
    input wire          reset,
    input wire          clk_en,
    // Register bus
    input wire [AW-1:0] avs_address,
    input wire          avs_write,
    input wire          avs_read,
    input wire [31:0]   avs_writedata,
    input wire [3:0]    avs_byteenable,
    input wire          avs_waitrequest_q,
    // Modulator side
    input wire          first_modulator_clear,
    input wire          ev_first_period,
    input wire [7:0]    pin_drive_q,
    input wire [7:0]    pin_level_q,
    input wire          first_modulator_run_q,
    input wire          group_modulator_run_q,
    input wire          first_clk_use_rc_q,
    input wire          first_clk_double_q,
    input wire          group_clk_use_rc_q,
    input wire          group_clk_double_q,
    input wire          irq_q
);
    // ------------------------------------------------------------------------
    // Shadow registers, rebuilt from accepted writes
    // ------------------------------------------------------------------------
    wire       acc = avs_write && !avs_waitrequest_q && avs_byteenable[0] && clk_en;
    wire [7:0] idx = avs_address[9:2];
    reg  [7:0] rt_q, md_q, rc_q, gt_q, ie_q, en_q;
    reg  [3:0] mp_q;
    wire       mcnd = md_q[6] && first_modulator_clear && ({rt_q[1:0], rc_q[1:0]} == mp_q);
    always @(posedge clk_sys) begin
        mp_q <= {rt_q[1:0], rc_q[1:0]};
        if (reset) begin
            {rt_q, md_q, rc_q, gt_q, ie_q, en_q} <= 48'h0;
        end else if (acc) begin
            if (idx == `PWMOS_IDX_ROUTE) rt_q <= avs_writedata[7:0];
            if (idx == `PWMOS_IDX_MODE) md_q <= avs_writedata[7:0];
            if (idx == `PWMOS_IDX_RUNCLK) rc_q <= avs_writedata[7:0];
            if (idx == `PWMOS_IDX_GATE) gt_q <= avs_writedata[7:0];
            if (idx == `PWMOS_IDX_MODIE) ie_q <= avs_writedata[7:0];
            if (idx == `PWMOS_IDX_IEN) en_q <= avs_writedata[7:0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    a_wait_once: assert property ($fell(avs_waitrequest_q) |=> avs_waitrequest_q)
        else $error("waitrequest low longer than one cycle");
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest_q |=>
        !avs_waitrequest_q) else $error("request not answered next cycle");
    a_pin_idle: assert property ((pin_level_q & ~pin_drive_q) == 8'h00)
        else $error("undriven pin shows a level");
    a_route_follow: assert property (pin_drive_q == $past(rt_q))
        else $error("pin drive differs from route register");
    a_irq_gate: assert property (irq_q |-> $past(gt_q[7]) && $past(ie_q[7]))
        else $error("interrupt passed a closed gate");
    a_irq_raise: assert property (ev_first_period && gt_q[7] && ie_q[7] && en_q[0]
        |-> ##[1:3] irq_q) else $error("enabled event raised no interrupt");
    a_run_copy: assert property (rc_q == $past(rc_q) |->
        first_modulator_run_q == rc_q[4] && group_modulator_run_q == rc_q[5])
        else $error("run output differs from run bit");
    a_clk_select: assert property (rc_q == $past(rc_q) |->
        first_clk_use_rc_q == rc_q[3] && first_clk_double_q == (rc_q[3:2] == 2'h3) &&
        group_clk_use_rc_q == rc_q[7] && group_clk_double_q == (rc_q[7:6] == 2'h3))
        else $error("clock select outputs wrong");
    a_mask_force: assert property (mcnd [*4] |->
        pin_level_q[1:0] == (rc_q[1:0] & rt_q[1:0])) else $error("mask level not forced");
    c_irq: cover property ($rose(irq_q));
    c_mask: cover property (mcnd [*4]);
    c_read: cover property (avs_read && !avs_waitrequest_q);
endmodule

bind pwmos_top pwmos_top_chk #(.DZ_W(DZ_W), .AW(AW)) u_chk (.clk_sys(clk_sys), .reset(reset),
    .clk_en(clk_en), .avs_address(avs_address), .avs_write(avs_write), .avs_read(avs_read),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest_q(avs_waitrequest_q), .first_modulator_clear(first_modulator_clear),
    .ev_first_period(ev_first_period), .pin_drive_q(pin_drive_q), .pin_level_q(pin_level_q),
    .first_modulator_run_q(first_modulator_run_q), .group_modulator_run_q(group_modulator_run_q),
    .first_clk_use_rc_q(first_clk_use_rc_q), .first_clk_double_q(first_clk_double_q),
    .group_clk_use_rc_q(group_clk_use_rc_q), .group_clk_double_q(group_clk_double_q),
    .irq_q(irq_q));

// *** tb.sv ***
// Self-checking bench of the modulator output stage
`timescale 1ns/100ps
`include "pwmos_consts.vh"
module tb;
    reg          clk_sys = 1'b0;
    reg          reset = 1'b1;
    reg  [9:0]   avs_address = 10'h000;
    reg          avs_read = 1'b0, avs_write = 1'b0;
    reg  [31:0]  avs_writedata = 32'h0;
    reg  [3:0]   avs_byteenable = 4'hF;
    reg          first_duty = 1'b0, first_low_duty = 1'b0, group_duty = 1'b0;
    reg          first_modulator_clear = 1'b0, ev_first_period = 1'b0, ev_group_period = 1'b0;
    wire [31:0]  avs_readdata_q;
    wire [7:0]   pin_drive_q, pin_level_q;
    wire         avs_waitrequest_q, irq_q, f_run, g_run, f_rc, f_x2, g_rc, g_x2;
    reg  [31:0]  seed, lat_n = 32'h0;
    reg  [31:0]  exp_q[$];
    reg          pin_chk = 1'b0, lat_chk = 1'b0;
    reg  [7:0]   r, rck = 8'h00;
    integer      n_errors = 0, cmp_count = 0, i, d, n;

    pwmos_top uut (.clk_sys(clk_sys), .reset(reset), .clk_en(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata_q(avs_readdata_q),
        .avs_waitrequest_q(avs_waitrequest_q), .first_duty(first_duty),
        .first_low_duty(first_low_duty), .group_duty(group_duty),
        .first_modulator_clear(first_modulator_clear), .ev_first_period(ev_first_period),
        .ev_group_period(ev_group_period), .pin_drive_q(pin_drive_q), .pin_level_q(pin_level_q),
        .first_modulator_run_q(f_run), .group_modulator_run_q(g_run),
        .first_clk_use_rc_q(f_rc), .first_clk_double_q(f_x2), .group_clk_use_rc_q(g_rc),
        .group_clk_double_q(g_x2), .irq_q(irq_q));

    always #4 clk_sys = ~clk_sys;

    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction

    task give_verdict;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
            if (n_errors == 0 && cmp_count > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    // ------------------------------------------------------------------------
    // Monitor: oldest expectation against whatever result shows up
    // ------------------------------------------------------------------------
    task check(input [31:0] got);
        reg [31:0] e;
        begin
            e = exp_q.pop_front();
            cmp_count = cmp_count + 1;
            if (got !== e) begin
                n_errors = n_errors + 1;
                $display("Error at %0t: expected %h, got %h", $time, e, got);
            end
        end
    endtask

    always @(posedge clk_sys) begin
        if (avs_read && avs_waitrequest_q === 1'b0)
            check(avs_readdata_q);
        if (pin_chk)
            check({9'h0, f_run, g_run, f_rc, f_x2, g_rc, g_x2, irq_q, pin_drive_q, pin_level_q});
        if (lat_chk)
            check(lat_n);
    end

    // ------------------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------------------
    task bus(input rd, input [7:0] idx, input [7:0] wd, input be0);
        integer k;
        begin
            seed = xs(seed);
            if (!rd && be0 && idx == `PWMOS_IDX_RUNCLK) rck = wd;
            avs_address <= {idx, 2'h0};
            avs_writedata <= {seed[31:8], wd};
            avs_byteenable <= {3'h7, be0};
            avs_read <= rd;
            avs_write <= !rd;
            k = 0;
            @(posedge clk_sys);
            while (avs_waitrequest_q !== 1'b0 && k < 50) begin
                @(posedge clk_sys);
                k = k + 1;
            end
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            if (k >= 50) begin
                n_errors = n_errors + 1;
                give_verdict;
            end
            @(posedge clk_sys);
        end
    endtask

    task rd_exp(input [7:0] idx, input [7:0] e);
        begin
            exp_q.push_back({24'h0, e});
            bus(1'b1, idx, 8'h00, 1'b1);
        end
    endtask

    task snap(input [7:0] drv, input [7:0] lvl, input irq);
        begin
            repeat (3) @(posedge clk_sys);
            exp_q.push_back({9'h0, rck[4], rck[5], rck[3], &rck[3:2], rck[7], &rck[7:6],
                             irq, drv, lvl});
            pin_chk <= 1'b1;
            @(posedge clk_sys);
            pin_chk <= 1'b0;
        end
    endtask

    task meas(input [3:0] nz);
        begin
            bus(1'b0, `PWMOS_IDX_MODE, {4'h0, nz}, 1'b1);
            first_duty <= 1'b0;
            repeat (20) @(posedge clk_sys);
            for (d = 0; d < 2; d = d + 1) begin
                first_duty <= (d == 0);
                n = 1;
                @(posedge clk_sys);
                while (pin_level_q[d] !== 1'b1 && n < 40) begin
                    @(posedge clk_sys);
                    n = n + 1;
                end
                if (n >= 40) begin
                    n_errors = n_errors + 1;
                    give_verdict;
                end
                exp_q.push_back(32'd3 + nz);
                lat_n <= n;
                lat_chk <= 1'b1;
                @(posedge clk_sys);
                lat_chk <= 1'b0;
            end
        end
    endtask

    initial begin
        seed = 32'hFAE1A7BA;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        rd_exp(`PWMOS_IDX_ROUTE, 8'h00);
        rd_exp(`PWMOS_IDX_MODE, 8'h00);
        rd_exp(`PWMOS_IDX_MODIE, 8'h00);
        rd_exp(`PWMOS_IDX_GATE, 8'h00);
        bus(1'b0, 8'h10, 8'h5A, 1'b1);
        rd_exp(8'h10, 8'h00);
        bus(1'b0, `PWMOS_IDX_RUNCLK, 8'h30, 1'b1);
        rd_exp(`PWMOS_IDX_RUNCLK, 8'h30);
        first_duty <= 1'b1;
        group_duty <= 1'b1;
        for (i = 0; i < 12; i = i + 1) begin
            seed = xs(seed);
            r = (i < 8) ? (8'h01 << i) : seed[7:0];
            bus(1'b0, `PWMOS_IDX_ROUTE, r, 1'b1);
            snap(r, r & 8'hF5, 1'b0);
        end
        bus(1'b0, `PWMOS_IDX_ROUTE, ~r, 1'b0);
        snap(r, r & 8'hF5, 1'b0);
        bus(1'b0, `PWMOS_IDX_ROUTE, 8'h03, 1'b1);
        for (i = 0; i < 4; i = i + 1) begin
            bus(1'b0, `PWMOS_IDX_MODE, i << 4, 1'b1);
            snap(8'h03, {6'h0, i[1], !i[0]}, 1'b0);
        end
        first_modulator_clear <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            bus(1'b0, `PWMOS_IDX_RUNCLK, 8'h30 | i, 1'b1);
            bus(1'b0, `PWMOS_IDX_MODE, 8'h70, 1'b1);
            snap(8'h03, i, 1'b0);
        end
        first_modulator_clear <= 1'b0;
        snap(8'h03, 8'h02, 1'b0);
        bus(1'b0, `PWMOS_IDX_MODE, 8'h80, 1'b1);
        first_low_duty <= 1'b1;
        snap(8'h03, 8'h03, 1'b0);
        first_low_duty <= 1'b0;
        snap(8'h03, 8'h01, 1'b0);
        bus(1'b0, `PWMOS_IDX_MODE, 8'h00, 1'b1);
        for (i = 0; i < 4; i = i + 1) begin
            bus(1'b0, `PWMOS_IDX_RUNCLK, {i[1:0], 2'h0, i[1:0], 2'h0}, 1'b1);
            snap(8'h03, 8'h00, 1'b0);
        end
        bus(1'b0, `PWMOS_IDX_RUNCLK, 8'h30, 1'b1);
        for (i = 0; i < 4; i = i + 1)
            meas(i * 5);
        bus(1'b0, `PWMOS_IDX_MODE, 8'h00, 1'b1);
        bus(1'b0, `PWMOS_IDX_GATE, 8'h80, 1'b1);
        bus(1'b0, `PWMOS_IDX_MODIE, 8'h80, 1'b1);
        bus(1'b0, `PWMOS_IDX_IEN, 8'h03, 1'b1);
        ev_first_period <= 1'b1;
        @(posedge clk_sys);
        ev_first_period <= 1'b0;
        snap(8'h03, 8'h02, 1'b1);
        rd_exp(`PWMOS_IDX_STS, 8'h01);
        bus(1'b0, `PWMOS_IDX_IEN, 8'h00, 1'b1);
        snap(8'h03, 8'h02, 1'b0);
        bus(1'b0, `PWMOS_IDX_IEN, 8'h03, 1'b1);
        bus(1'b0, `PWMOS_IDX_MODIE, 8'h00, 1'b1);
        snap(8'h03, 8'h02, 1'b0);
        bus(1'b0, `PWMOS_IDX_MODIE, 8'h80, 1'b1);
        bus(1'b0, `PWMOS_IDX_GATE, 8'h00, 1'b1);
        snap(8'h03, 8'h02, 1'b0);
        bus(1'b0, `PWMOS_IDX_GATE, 8'h80, 1'b1);
        ev_group_period <= 1'b1;
        @(posedge clk_sys);
        ev_group_period <= 1'b0;
        rd_exp(`PWMOS_IDX_STS, 8'h03);
        bus(1'b0, `PWMOS_IDX_CLR, 8'h03, 1'b1);
        rd_exp(`PWMOS_IDX_STS, 8'h00);
        rd_exp(`PWMOS_IDX_CLR, 8'h00);
        snap(8'h03, 8'h02, 1'b0);
        repeat (4) @(posedge clk_sys);
        give_verdict;
    end
endmodule
